// [common/owst_pkg.sv]
// Shared constants and types for the single-wire status write slave
package owst_pkg;

  // Clock and slot timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RST_US      = 480;
  localparam int T_PDH_US      = 30;
  localparam int T_PDL_US      = 120;
  localparam int T_SAMPLE_US   = 30;
  localparam int T_RDV_US      = 15;
  localparam int RST_CYC       = T_RST_US * 1000 / CLK_PERIOD_NS;
  localparam int PDH_CYC       = T_PDH_US * 1000 / CLK_PERIOD_NS;
  localparam int PDL_CYC       = T_PDL_US * 1000 / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC    = T_SAMPLE_US * 1000 / CLK_PERIOD_NS;
  localparam int RDV_CYC       = T_RDV_US * 1000 / CLK_PERIOD_NS;
  localparam int TMR_W         = 17;

  // Commands
  localparam logic [7:0] CMD_READ_ROM   = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM  = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM   = 8'hcc;
  localparam logic [7:0] CMD_WR_STATUS  = 8'h55;

  // Reflected form of x^8 + x^5 + x^4 + 1
  localparam logic [7:0] CRC_POLY_REFL  = 8'h8c;
  localparam logic [7:0] CRC_INIT       = 8'h00;

  // Status field: bytes 0..6 erased to ones, byte 7 preset to zero
  localparam logic [63:0] STAT_RST      = 64'h00ff_ffff_ffff_ffff;

  localparam int ROM_BITS = 64;
  localparam int ROM_CRC_BITS = 56;

  typedef enum logic [3:0] {
    OWST_WAIT   = 4'h0,
    OWST_RST    = 4'h1,
    OWST_PWAIT  = 4'h2,
    OWST_PDRV   = 4'h3,
    OWST_ROMCMD = 4'h4,
    OWST_ROMRD  = 4'h5,
    OWST_MATCH  = 4'h6,
    OWST_MEMCMD = 4'h7,
    OWST_ADLO   = 4'h8,
    OWST_ADHI   = 4'h9,
    OWST_DATA   = 4'ha,
    OWST_CRC    = 4'hb,
    OWST_VER    = 4'hc
  } owst_state_e;

  function automatic logic [7:0] owst_rom_crc(input logic [55:0] d);
    logic [7:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 0; i < ROM_CRC_BITS; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
    end
    return c;
  endfunction

endpackage

// [src/owst_crc8.sv]
// One serial step of the 8-bit CRC, fed least significant bit first
`timescale 1ns/1ns
`default_nettype none
module owst_crc8 (
  input  wire logic [7:0] crc_i,
  input  wire logic       bit_i,
  output logic      [7:0] crc_o
);
  logic fb;

  always_comb begin
    fb    = crc_i[0] ^ bit_i;
    crc_o = {1'b0, crc_i[7:1]} ^ (fb ? owst_pkg::CRC_POLY_REFL : 8'h00);
  end
endmodule
`default_nettype wire

// [src/owst_slave.sv]
// Slave command logic: reset/presence, ROM commands and status write
`timescale 1ns/1ns
`default_nettype none
module owst_slave #(
  parameter logic [7:0]  FAMILY_CODE = 8'h5a,               // Arbitrary value
  parameter logic [47:0] SERIAL_NUM  = 48'h0000_0012_3456,  // Arbitrary value
  parameter int          RST_CYC     = owst_pkg::RST_CYC,
  parameter int          PDH_CYC     = owst_pkg::PDH_CYC,
  parameter int          PDL_CYC     = owst_pkg::PDL_CYC,
  parameter int          SAMPLE_CYC  = owst_pkg::SAMPLE_CYC,
  parameter int          RDV_CYC     = owst_pkg::RDV_CYC
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic dq_i,
  output logic      dq_o,
  output logic      dq_oe_n_o,
  input  wire logic prog_pulse_i
);
  localparam int TW = owst_pkg::TMR_W;
  localparam logic [55:0] ROM_BODY = {SERIAL_NUM, FAMILY_CODE};
  localparam logic [63:0] ROM_CODE = {owst_pkg::owst_rom_crc(ROM_BODY), ROM_BODY};
  localparam logic [TW-1:0] RST_T  = TW'(RST_CYC - 1);
  localparam logic [TW-1:0] PDH_T  = TW'(PDH_CYC - 1);
  localparam logic [TW-1:0] PDL_T  = TW'(PDL_CYC - 1);
  localparam logic [TW-1:0] SMP_T  = TW'(SAMPLE_CYC - 1);
  localparam logic [TW-1:0] RDV_T  = TW'(RDV_CYC - 1);

  typedef struct packed {
    owst_pkg::owst_state_e state;
    logic [TW-1:0]         tmr;
    logic [TW-1:0]         lowcnt;
    logic                  slot;
    logic                  oe_n;
    logic                  prev;
    logic [6:0]            bcnt;
    logic [63:0]           sh;
    logic                  match;
    logic [7:0]            crc;
    logic [15:0]           addr;
    logic [7:0]            data;
    logic [7:0][7:0]       stat;
  } owst_state_s;

  owst_state_s r_reg;
  owst_state_s r_next;
  logic        tx;
  logic        fall;
  logic        bit_done;
  logic        last;
  logic        crc_en;
  logic [7:0]  crc_step;
  logic [7:0]  rx_byte;
  logic [2:0]  idx;
  logic [7:0]  prog_val;

  owst_crc8 u_crc (
    .crc_i (r_reg.crc),
    .bit_i (dq_i),
    .crc_o (crc_step)
  );

  always_comb begin
    r_next   = r_reg;
    idx      = r_reg.addr[2:0];
    tx       = (r_reg.state == owst_pkg::OWST_ROMRD) || (r_reg.state == owst_pkg::OWST_CRC) ||
               (r_reg.state == owst_pkg::OWST_VER);
    // Own drive must not look like a master slot start
    fall     = r_reg.prev & ~dq_i & r_reg.oe_n;
    bit_done = 1'b0;
    last     = 1'b0;
    crc_en   = (r_reg.state == owst_pkg::OWST_MEMCMD) || (r_reg.state == owst_pkg::OWST_ADLO) ||
               (r_reg.state == owst_pkg::OWST_ADHI) || (r_reg.state == owst_pkg::OWST_DATA);
    rx_byte  = {dq_i, r_reg.sh[7:1]};
    prog_val = r_reg.stat[idx] & r_reg.data;
    r_next.prev = dq_i;
    if (dq_i) begin
      r_next.lowcnt = '0;
    end else if (r_reg.lowcnt != RST_T) begin
      r_next.lowcnt = r_reg.lowcnt + TW'(1);
    end

    if (!dq_i && r_reg.lowcnt == RST_T) begin
      // A long low wins over whatever was in progress
      r_next.state = owst_pkg::OWST_RST;
      r_next.slot  = 1'b0;
      r_next.oe_n  = 1'b1;
    end else begin
      case (r_reg.state)
        owst_pkg::OWST_WAIT: begin
          r_next.slot = 1'b0;
        end
        owst_pkg::OWST_RST: begin
          r_next.tmr = '0;
          if (dq_i) begin
            r_next.state = owst_pkg::OWST_PWAIT;
          end
        end
        owst_pkg::OWST_PWAIT: begin
          r_next.tmr = r_reg.tmr + TW'(1);
          if (r_reg.tmr == PDH_T) begin
            r_next.state = owst_pkg::OWST_PDRV;
            r_next.oe_n  = 1'b0;
            r_next.tmr   = '0;
          end
        end
        owst_pkg::OWST_PDRV: begin
          r_next.tmr = r_reg.tmr + TW'(1);
          if (r_reg.tmr == PDL_T) begin
            r_next.state = owst_pkg::OWST_ROMCMD;
            r_next.oe_n  = 1'b1;
            r_next.bcnt  = '0;
            r_next.slot  = 1'b0;
          end
        end
        default: begin
          if (r_reg.state == owst_pkg::OWST_VER && r_reg.bcnt == 7'h00 && !r_reg.slot &&
              prog_pulse_i) begin
            // Programming never checks the CRC; the master alone decides
            r_next.stat[idx]  = prog_val;
            r_next.sh[7:0]    = prog_val;
          end
          if (fall) begin
            r_next.slot = 1'b1;
            r_next.tmr  = '0;
            if (tx) begin
              r_next.oe_n = r_reg.sh[0];
            end
          end else if (r_reg.slot) begin
            r_next.tmr = r_reg.tmr + TW'(1);
            if (r_reg.tmr == (tx ? RDV_T : SMP_T)) begin
              r_next.slot = 1'b0;
              r_next.oe_n = 1'b1;
              bit_done    = 1'b1;
            end
          end
        end
      endcase

      if (bit_done) begin
        last = (r_reg.state == owst_pkg::OWST_ROMRD || r_reg.state == owst_pkg::OWST_MATCH) ?
               (r_reg.bcnt == 7'h3f) : (r_reg.bcnt == 7'h07);
        r_next.bcnt = last ? 7'h00 : r_reg.bcnt + 7'h01;
        r_next.sh   = tx ? {1'b0, r_reg.sh[63:1]} : {r_reg.sh[63:8], rx_byte};
        if (crc_en) begin
          r_next.crc = crc_step;
        end
        case (r_reg.state)
          owst_pkg::OWST_ROMCMD: begin
            if (last) begin
              r_next.crc   = owst_pkg::CRC_INIT;
              r_next.match = 1'b1;
              case (rx_byte)
                owst_pkg::CMD_READ_ROM: begin
                  r_next.state = owst_pkg::OWST_ROMRD;
                  r_next.sh    = ROM_CODE;
                end
                owst_pkg::CMD_MATCH_ROM: r_next.state = owst_pkg::OWST_MATCH;
                owst_pkg::CMD_SKIP_ROM:  r_next.state = owst_pkg::OWST_MEMCMD;
                default:                 r_next.state = owst_pkg::OWST_WAIT;
              endcase
            end
          end
          owst_pkg::OWST_ROMRD: begin
            if (last) begin
              r_next.state = owst_pkg::OWST_MEMCMD;
            end
          end
          owst_pkg::OWST_MATCH: begin
            if (dq_i != ROM_CODE[r_reg.bcnt[5:0]]) begin
              r_next.match = 1'b0;
            end
            if (last) begin
              r_next.state = (r_next.match) ? owst_pkg::OWST_MEMCMD : owst_pkg::OWST_WAIT;
            end
          end
          owst_pkg::OWST_MEMCMD: begin
            if (last) begin
              // Other memory commands are not served here; release until reset
              r_next.state = (rx_byte == owst_pkg::CMD_WR_STATUS) ? owst_pkg::OWST_ADLO :
                             owst_pkg::OWST_WAIT;
            end
          end
          owst_pkg::OWST_ADLO: begin
            if (last) begin
              r_next.addr[7:0] = rx_byte;
              r_next.state     = owst_pkg::OWST_ADHI;
            end
          end
          owst_pkg::OWST_ADHI: begin
            if (last) begin
              r_next.addr[15:8] = rx_byte;
              r_next.state      = owst_pkg::OWST_DATA;
            end
          end
          owst_pkg::OWST_DATA: begin
            if (last) begin
              r_next.data    = rx_byte;
              r_next.sh[7:0] = crc_step;
              r_next.state   = owst_pkg::OWST_CRC;
            end
          end
          owst_pkg::OWST_CRC: begin
            if (last) begin
              r_next.sh[7:0] = r_reg.stat[idx];
              r_next.state   = owst_pkg::OWST_VER;
            end
          end
          owst_pkg::OWST_VER: begin
            if (last) begin
              // Advance even after a failed verify
              r_next.addr  = r_reg.addr + 16'h0001;
              r_next.crc   = r_next.addr[7:0];
              r_next.state = owst_pkg::OWST_DATA;
            end
          end
          default: begin
            r_next.state = r_reg.state;
          end
        endcase
      end
    end
    // Byte 7 is fixed at zero whatever is written
    r_next.stat[7] = 8'h00;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg      <= '0;
      r_reg.oe_n <= 1'b1;
      r_reg.prev <= 1'b1;
      r_reg.stat <= owst_pkg::STAT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign dq_oe_n_o = r_reg.oe_n;
  assign dq_o      = 1'b0;

  a_reset_abort: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!dq_i && r_reg.lowcnt == RST_T) |=> (r_reg.state == owst_pkg::OWST_RST && r_reg.oe_n))
    else $error("Bus reset did not abort the sequence");

  a_presence_drv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.state == owst_pkg::OWST_PWAIT && r_reg.tmr == PDH_T && dq_i)
      |=> (!dq_oe_n_o && r_reg.state == owst_pkg::OWST_PDRV))
    else $error("Presence pulse not started after wait");

  a_byte7_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    r_reg.stat[7] == 8'h00)
    else $error("Status byte 7 not zero");

  // A programmed zero can never come back as a one
  a_stat_clear_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.stat & ~$past(r_reg.stat)) == 64'h0)
    else $error("Status bit returned to one");

  a_prog_and: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.state == owst_pkg::OWST_VER && r_reg.bcnt == 7'h00 && !r_reg.slot && prog_pulse_i &&
     r_reg.lowcnt != RST_T && r_reg.addr[2:0] != 3'h7)
      |=> r_reg.stat[$past(r_reg.addr[2:0])] ==
          ($past(r_reg.data) & $past(r_reg.stat[r_reg.addr[2:0]])))
    else $error("Programming did not AND data into status byte");

  a_addr_incr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.state == owst_pkg::OWST_VER && bit_done && r_reg.bcnt == 7'h07)
      |=> (r_reg.addr == $past(r_reg.addr) + 16'h0001 && r_reg.crc == r_reg.addr[7:0] &&
           r_reg.state == owst_pkg::OWST_DATA))
    else $error("Address not advanced or CRC not reloaded after verify");

  a_wr_decode: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.state == owst_pkg::OWST_MEMCMD && bit_done && r_reg.bcnt == 7'h07 &&
     rx_byte == owst_pkg::CMD_WR_STATUS) |=> r_reg.state == owst_pkg::OWST_ADLO)
    else $error("Status write command not taken");

  a_skip_rom: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.state == owst_pkg::OWST_ROMCMD && bit_done && r_reg.bcnt == 7'h07 &&
     rx_byte == owst_pkg::CMD_SKIP_ROM) |=> r_reg.state == owst_pkg::OWST_MEMCMD)
    else $error("Skip ROM did not reach memory command");

  a_match_fail: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.state == owst_pkg::OWST_MATCH && bit_done && r_reg.bcnt == 7'h3f &&
     (!r_reg.match || dq_i != ROM_CODE[63])) |=> r_reg.state == owst_pkg::OWST_WAIT)
    else $error("Mismatched ROM code still proceeded");

  a_drive_legal: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !dq_oe_n_o |-> (r_reg.state == owst_pkg::OWST_PDRV || (r_reg.slot && tx)))
    else $error("Line driven outside presence or a read slot");

  a_crc_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (r_reg.state == owst_pkg::OWST_DATA && bit_done && r_reg.bcnt == 7'h07)
      |=> (r_reg.sh[7:0] == r_reg.crc && r_reg.state == owst_pkg::OWST_CRC))
    else $error("CRC not loaded for return");

  a_slot_sync: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (fall && r_reg.state >= owst_pkg::OWST_ROMCMD && !(!dq_i && r_reg.lowcnt == RST_T))
      |=> (r_reg.slot && r_reg.tmr == '0))
    else $error("Slot not started on falling edge");
endmodule
`default_nettype wire

// [dv/owst_master.sv]
// Behavioural bus master that makes resets, slots and the programming pulse
`timescale 1ns/1ns
`default_nettype none
module owst_master (
  input  wire logic clk_i,
  input  wire logic dq_i,
  output logic      dq_low_o,
  output logic      prog_o
);
  initial begin
    dq_low_o = 1'b0; // Released line idles high through the pull-up
    prog_o   = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Presence is looked for in a bounded window after the line is released
  task automatic bus_reset(output logic seen);
    seen = 1'b0;
    dq_low_o = 1'b1;
    idle(50);
    dq_low_o = 1'b0;
    for (int i = 0; i < 40; i++) begin
      idle(1);
      if (dq_i === 1'b0) begin
        seen = 1'b1;
      end
    end
  endtask

  task automatic wbit(input logic b);
    dq_low_o = 1'b1; // Each slot opens with a falling edge
    idle(b ? 2 : 10);
    dq_low_o = 1'b0;
    idle(b ? 10 : 2);
  endtask

  // Sampled two cycles after release, inside the device's hold time
  task automatic rbit(output logic b);
    dq_low_o = 1'b1;
    idle(1);
    dq_low_o = 1'b0;
    idle(2);
    b = dq_i;
    idle(9);
  endtask

  task automatic wbyte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) wbit(v[i]);
  endtask

  task automatic rbyte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) rbit(v[i]);
  endtask

  task automatic pulse();
    idle(2);
    prog_o = 1'b1;
    idle(20);
    prog_o = 1'b0;
    idle(2);
  endtask
endmodule
`default_nettype wire

// [dv/owst_slave_test.sv]
// Self-checking bench for the status write slave
`timescale 1ns/1ns
`default_nettype none
module owst_slave_test;
  localparam logic [7:0]  FAM = 8'h5a;               // Arbitrary, same as the device default
  localparam logic [47:0] SER = 48'h0000_0012_3456;  // Arbitrary, same as the device default
  logic        clk_i = 1'b0;
  logic        arst_n_i;
  logic        dq_low;
  logic        prog;
  logic        dq_o;
  logic        dq_oe_n;
  wire         dq_line;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [7:0]  stat [8];
  logic [63:0] rom;

  // Wired-AND of master pull-down, device drive and pull-up
  assign dq_line = ~dq_low & (dq_oe_n | dq_o);

  owst_slave #(.RST_CYC(40), .PDH_CYC(4), .PDL_CYC(8), .SAMPLE_CYC(6), .RDV_CYC(3)) dut (
    .clk_i        (clk_i),
    .arst_n_i     (arst_n_i),
    .dq_i         (dq_line),
    .dq_o         (dq_o),
    .dq_oe_n_o    (dq_oe_n),
    .prog_pulse_i (prog)
  );

  owst_master m (
    .clk_i    (clk_i),
    .dq_i     (dq_line),
    .dq_low_o (dq_low),
    .prog_o   (prog)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ b[i];
      c = {1'b0, c[7:1]} ^ (fb ? 8'h8c : 8'h00);
    end
    return c;
  endfunction

  function automatic logic [63:0] rom_code();
    logic [7:0] c;
    c = crc_step(8'h00, FAM);
    for (int i = 0; i < 6; i++) c = crc_step(c, SER[8*i +: 8]);
    return {c, SER, FAM};
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic open_bus(input logic [7:0] cmd, input logic [63:0] code);
    logic p;
    m.bus_reset(p);
    check({7'h00, p}, 8'h01);
    m.wbyte(cmd);
    if (cmd == 8'h55) begin
      for (int i = 0; i < 8; i++) m.wbyte(code[8*i +: 8]);
    end
  endtask

  task automatic ws_pass(input logic first, input logic [15:0] a, input logic [7:0] d,
                         input logic pls);
    logic [7:0] c;
    logic [7:0] got;
    c = a[7:0];
    if (first) begin
      m.wbyte(8'h55);
      m.wbyte(a[7:0]);
      m.wbyte(a[15:8]);
      c = crc_step(crc_step(crc_step(8'h00, 8'h55), a[7:0]), a[15:8]);
    end
    m.wbyte(d);
    m.rbyte(got);
    check(got, crc_step(c, d));
    // Pulse only after a good CRC, as a careful master would
    if (pls && got === crc_step(c, d)) begin
      m.pulse();
      stat[a[2:0]] = stat[a[2:0]] & d;
    end
    m.rbyte(got);
    check(got, stat[a[2:0]]);
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    logic [15:0] a;
    logic [7:0]  got;
    arst_n_i = 1'b0;
    for (int i = 0; i < 7; i++) stat[i] = 8'hff;
    stat[7] = 8'h00;
    rom = rom_code();
    void'($urandom(32'h2958afdb));
    repeat (4) @(negedge clk_i);
    arst_n_i = 1'b1;
    for (int t = 0; t < 3; t++) begin
      open_bus(8'hcc, rom);
      a = 16'($urandom);
      ws_pass(1'b1, a, 8'($urandom), 1'b1);
      for (int k = 0; k < 3; k++) begin
        a = a + 16'h0001;
        ws_pass(1'b0, a, 8'($urandom), 1'($urandom));
      end
    end
    // Address carry into the high byte reloads a zero low byte
    open_bus(8'hcc, rom);
    ws_pass(1'b1, 16'h00ff, 8'h5a, 1'b1);
    ws_pass(1'b0, 16'h0100, 8'h0f, 1'b1);
    open_bus(8'hcc, rom);
    ws_pass(1'b1, 16'h0007, 8'hff, 1'b1);
    for (int k = 0; k < 2; k++) begin
      open_bus(8'hcc, rom);
      ws_pass(1'b1, 16'h0001, k ? 8'h3c : 8'hf0, 1'b1);
    end
    open_bus(8'h33, rom);
    for (int i = 0; i < 8; i++) begin
      m.rbyte(got);
      check(got, rom[8*i +: 8]);
    end
    ws_pass(1'b1, 16'h0002, 8'($urandom), 1'b1);
    open_bus(8'h55, rom);
    ws_pass(1'b1, 16'h0004, 8'($urandom), 1'b1);
    // Reset in the middle of the address phase
    open_bus(8'hcc, rom);
    m.wbyte(8'h55);
    m.wbyte(8'h05);
    open_bus(8'hcc, rom);
    ws_pass(1'b1, 16'h0005, 8'h81, 1'b1);
    // Wrong match code, unknown ROM command or unserved memory command: silent until reset
    for (int k = 0; k < 3; k++) begin
      open_bus(k == 0 ? 8'h55 : (k == 1 ? 8'h0f : 8'hcc), {~rom[63], rom[62:0]});
      for (int j = 0; j < 4; j++) m.wbyte((j == 0 && k != 2) ? 8'h55 : 8'h00);
      m.rbyte(got);
      check(got, 8'hff);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
